// ===== rtl/ddsc_pkg.sv
// Constants and types for the downconverter sync and decimation control
package ddsc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] DDSC_ADDR_SYNC = 12'h300;
    localparam logic [11:0] DDSC_ADDR_CTRL = 12'h310;
    localparam logic [11:0] DDSC_ADDR_INSEL = 12'h311;
    localparam logic [7:0] DDSC_SYNC_RST = 8'h00;
    localparam logic [7:0] DDSC_CTRL_RST = 8'h00;
    localparam logic [7:0] DDSC_INSEL_RST = 8'h00;
    localparam logic [7:0] DDSC_SYNC_MASK = 8'h93;
    localparam logic [7:0] DDSC_CTRL_MASK = 8'h7f;
    localparam logic [7:0] DDSC_INSEL_MASK = 8'hf0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DDSC_SYNC_EN_BIT = 0;
    localparam int DDSC_ONE_SHOT_BIT = 1;
    localparam int DDSC_SOFT_RST_BIT = 4;
    localparam int DDSC_GAIN_BIT = 6;
    localparam int DDSC_IF_LSB = 4;
    localparam int DDSC_REAL_BIT = 3;
    localparam int DDSC_DEC_LSB = 0;
    localparam int DDSC_EXT_LSB = 4;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] DDSC_DEC_EXT = 3'h7;
    localparam logic [3:0] DDSC_EXT_HB4_TB = 4'h0;
    localparam logic [3:0] DDSC_EXT_HB1_FB = 4'h2;
    localparam logic [3:0] DDSC_EXT_HB2_FB = 4'h3;

    typedef enum logic [1:0] {
        DDSC_IF_VARIABLE = 2'b00,
        DDSC_IF_ZERO = 2'b01,
        DDSC_IF_QUARTER = 2'b10,
        DDSC_IF_TEST = 2'b11
    } ddsc_if_mode_t;

    typedef enum logic [1:0] {
        DDSC_SY_IDLE = 2'b00,
        DDSC_SY_ARMED = 2'b01,
        DDSC_SY_CONT = 2'b10
    } ddsc_sync_state_t;

endpackage

// ===== rtl/ddsc_cfg_if.sv
// Decimation codes carried from control top to the filter chain decoder, decoded configuration carried back
`timescale 1ns/1ns
interface ddsc_cfg_if;
    logic [2:0] dec_code;
    logic [3:0] ext_code;
    logic real_out;
    logic [3:0] hb_count;
    logic third_band;
    logic fifth_band;
    logic [5:0] dec_ratio;
    logic cfg_valid;

    modport ctrl
    (
        output dec_code,
        output ext_code,
        output real_out,
        input hb_count,
        input third_band,
        input fifth_band,
        input dec_ratio,
        input cfg_valid
    );

    modport dec
    (
        input dec_code,
        input ext_code,
        input real_out,
        output hb_count,
        output third_band,
        output fifth_band,
        output dec_ratio,
        output cfg_valid
    );
endinterface

// ===== rtl/ddsc_chain_dec.sv
// Combinational decoder from decimation codes to filter stage selection
`timescale 1ns/1ns
module ddsc_chain_dec
    import ddsc_pkg::*;
(
    ddsc_cfg_if.dec cfg
);
    logic [5:0] cplx;

    always_comb
    begin
        cfg.hb_count = 4'h0;
        cfg.third_band = 1'b0;
        cfg.fifth_band = 1'b0;
        cfg.cfg_valid = 1'b1;
        cplx = 6'h00;
        unique case (cfg.dec_code)
            3'h0: begin cfg.hb_count = 4'h2; cplx = 6'h04; end
            3'h1: begin cfg.hb_count = 4'h3; cplx = 6'h08; end
            3'h2: begin cfg.hb_count = 4'h4; cplx = 6'h10; end
            3'h3: begin cfg.hb_count = 4'h1; cplx = 6'h02; end
            3'h4:
            begin
                cfg.hb_count = 4'h1;
                cfg.third_band = 1'b1;
                cplx = 6'h06;
            end
            3'h5:
            begin
                cfg.hb_count = 4'h2;
                cfg.third_band = 1'b1;
                cplx = 6'h0c;
            end
            3'h6:
            begin
                cfg.hb_count = 4'h3;
                cfg.third_band = 1'b1;
                cplx = 6'h18;
            end
            3'h7:
            begin
                // Extended field only consulted here
                if (cfg.ext_code == DDSC_EXT_HB4_TB)
                begin
                    cfg.hb_count = 4'h4;
                    cfg.third_band = 1'b1;
                    cplx = 6'h30;
                end
                else if (cfg.ext_code == DDSC_EXT_HB1_FB)
                begin
                    cfg.hb_count = 4'h1;
                    cfg.fifth_band = 1'b1;
                    cplx = 6'h0a;
                end
                else if (cfg.ext_code == DDSC_EXT_HB2_FB)
                begin
                    cfg.hb_count = 4'h2;
                    cfg.fifth_band = 1'b1;
                    cplx = 6'h14;
                end
                else
                begin
                    cfg.cfg_valid = 1'b0;
                end
            end
        endcase
        // Real output halves the ratio
        cfg.dec_ratio = cfg.real_out ? {1'b0, cplx[5:1]} : cplx;
    end
endmodule

// ===== rtl/ddsc_ctrl.sv
// Downconverter sync, gain, mixing mode and decimation control top
`timescale 1ns/1ns
module ddsc_ctrl
    import ddsc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic sysref_pin,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic nco_sync,
    output logic nco_reset,
    output logic gain_x2,
    output logic [1:0] if_mode,
    output logic real_out,
    output logic [3:0] hb_count,
    output logic third_band,
    output logic fifth_band,
    output logic [5:0] dec_ratio,
    output logic cfg_valid
);

    // ------------------------------------------------------------------
    // Reference input synchroniser and edge detect
    // ------------------------------------------------------------------
    logic sr_meta_q, sr_sync_q, sr_prev_q;
    logic sr_edge;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sr_meta_q <= 1'b0;
            sr_sync_q <= 1'b0;
            sr_prev_q <= 1'b0;
        end
        else
        begin
            sr_meta_q <= sysref_pin;
            sr_sync_q <= sr_meta_q;
            sr_prev_q <= sr_sync_q;
        end
    end

    assign sr_edge = sr_sync_q & ~sr_prev_q;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] sync_q, sync_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] insel_q, insel_d;
    logic [7:0] rdata_q, rdata_d;
    logic sync_fire;

    always_comb
    begin
        sync_d = sync_q;
        ctrl_d = ctrl_q;
        insel_d = insel_q;
        if (reg_wr && reg_addr == DDSC_ADDR_SYNC)
        begin
            sync_d = reg_wdata & DDSC_SYNC_MASK;
        end
        if (reg_wr && reg_addr == DDSC_ADDR_CTRL)
        begin
            ctrl_d = reg_wdata & DDSC_CTRL_MASK;
        end
        if (reg_wr && reg_addr == DDSC_ADDR_INSEL)
        begin
            insel_d = reg_wdata & DDSC_INSEL_MASK;
        end
        // One-shot completion clears enable, even over a same-cycle write
        if (sync_fire && sync_q[DDSC_ONE_SHOT_BIT])
        begin
            sync_d[DDSC_SYNC_EN_BIT] = 1'b0;
        end
        unique case (reg_addr)
            DDSC_ADDR_SYNC: rdata_d = sync_q;
            DDSC_ADDR_CTRL: rdata_d = ctrl_q;
            DDSC_ADDR_INSEL: rdata_d = insel_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_q <= DDSC_SYNC_RST;
            ctrl_q <= DDSC_CTRL_RST;
            insel_q <= DDSC_INSEL_RST;
            rdata_q <= 8'h00;
        end
        else
        begin
            sync_q <= sync_d;
            ctrl_q <= ctrl_d;
            insel_q <= insel_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Sync sequencer
    // ------------------------------------------------------------------
    ddsc_sync_state_t st_q, st_d;
    logic nco_sync_q, nco_sync_d;
    logic soft_rst;

    assign soft_rst = sync_q[DDSC_SOFT_RST_BIT];

    always_comb
    begin
        st_d = st_q;
        sync_fire = 1'b0;
        unique case (st_q)
            DDSC_SY_IDLE:
            begin
                if (sync_q[DDSC_SYNC_EN_BIT])
                begin
                    st_d = sync_q[DDSC_ONE_SHOT_BIT] ? DDSC_SY_ARMED : DDSC_SY_CONT;
                end
            end
            DDSC_SY_ARMED:
            begin
                if (!sync_q[DDSC_SYNC_EN_BIT])
                begin
                    st_d = DDSC_SY_IDLE;
                end
                else if (sr_edge)
                begin
                    sync_fire = 1'b1;
                    st_d = DDSC_SY_IDLE;
                end
            end
            DDSC_SY_CONT:
            begin
                if (!sync_q[DDSC_SYNC_EN_BIT] || sync_q[DDSC_ONE_SHOT_BIT])
                begin
                    st_d = DDSC_SY_IDLE;
                end
                else if (sr_edge)
                begin
                    sync_fire = 1'b1;
                end
            end
            default: st_d = DDSC_SY_IDLE;
        endcase
        nco_sync_d = sync_fire;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= DDSC_SY_IDLE;
            nco_sync_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            nco_sync_q <= nco_sync_d;
        end
    end

    // ------------------------------------------------------------------
    // Datapath configuration outputs
    // ------------------------------------------------------------------
    ddsc_cfg_if cfg ();

    assign cfg.dec_code = ctrl_q[DDSC_DEC_LSB +: 3];
    assign cfg.ext_code = insel_q[DDSC_EXT_LSB +: 4];
    assign cfg.real_out = ctrl_q[DDSC_REAL_BIT];

    ddsc_chain_dec u_dec
    (
        .cfg(cfg)
    );

    logic nco_reset_q, gain_q, real_q, tb_q, fb_q, valid_q;
    logic [1:0] if_q;
    logic [3:0] hb_q;
    logic [5:0] ratio_q;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nco_reset_q <= 1'b0;
            gain_q <= 1'b0;
            if_q <= DDSC_IF_VARIABLE;
            real_q <= 1'b0;
            hb_q <= 4'h0;
            tb_q <= 1'b0;
            fb_q <= 1'b0;
            ratio_q <= 6'h00;
            valid_q <= 1'b0;
        end
        else
        begin
            nco_reset_q <= soft_rst;
            gain_q <= ctrl_q[DDSC_GAIN_BIT];
            if_q <= ctrl_q[DDSC_IF_LSB +: 2];
            real_q <= ctrl_q[DDSC_REAL_BIT];
            hb_q <= cfg.hb_count;
            tb_q <= cfg.third_band;
            fb_q <= cfg.fifth_band;
            ratio_q <= cfg.dec_ratio;
            valid_q <= cfg.cfg_valid;
        end
    end

    assign reg_rdata = rdata_q;
    assign nco_sync = nco_sync_q;
    assign nco_reset = nco_reset_q;
    assign gain_x2 = gain_q;
    assign if_mode = if_q;
    assign real_out = real_q;
    assign hb_count = hb_q;
    assign third_band = tb_q;
    assign fifth_band = fb_q;
    assign dec_ratio = ratio_q;
    assign cfg_valid = valid_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_oneshot_clear;
        @(posedge mclk) disable iff (!arst_n)
        (st_q == DDSC_SY_ARMED && sync_q[DDSC_SYNC_EN_BIT] && sr_edge)
            |=> !sync_q[DDSC_SYNC_EN_BIT] ##0 nco_sync;
    endproperty
    a_oneshot_clear: assert property (p_oneshot_clear)
        else $error("one-shot sync did not clear enable");

    property p_no_sync_disabled;
        @(posedge mclk) disable iff (!arst_n)
        !sync_q[DDSC_SYNC_EN_BIT] |=> !nco_sync;
    endproperty
    a_no_sync_disabled: assert property (p_no_sync_disabled)
        else $error("sync pulse while enable low");

    property p_gain;
        @(posedge mclk) disable iff (!arst_n)
        ##1 gain_x2 == $past(ctrl_q[DDSC_GAIN_BIT]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain output mismatch");

    property p_if_mode;
        @(posedge mclk) disable iff (!arst_n)
        $changed(ctrl_q[5:4]) |=> if_mode == $past(ctrl_q[5:4]);
    endproperty
    a_if_mode: assert property (p_if_mode)
        else $error("IF mode not followed");

    property p_real_half;
        @(posedge mclk) disable iff (!arst_n)
        (ctrl_q[2:0] == 3'h3) |=> dec_ratio == (real_out ? 6'h01 : 6'h02);
    endproperty
    a_real_half: assert property (p_real_half)
        else $error("first half-band ratio wrong");

    property p_ext_ignored;
        @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && ctrl_q[2:0] != DDSC_DEC_EXT && $stable(ctrl_q)) |=> $stable(dec_ratio);
    endproperty
    a_ext_ignored: assert property (p_ext_ignored)
        else $error("extended field affected primary decimation");

    property p_ext48;
        @(posedge mclk) disable iff (!arst_n)
        (ctrl_q[2:0] == DDSC_DEC_EXT && insel_q[7:4] == DDSC_EXT_HB4_TB && !ctrl_q[3])
            |=> dec_ratio == 6'h30 && third_band && hb_count == 4'h4;
    endproperty
    a_ext48: assert property (p_ext48)
        else $error("extended code zero chain wrong");

    property p_soft_rst;
        @(posedge mclk) disable iff (!arst_n)
        soft_rst |=> nco_reset;
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset not applied");

    property p_reserved;
        @(posedge mclk) disable iff (!arst_n)
        ##1 (sync_q & ~DDSC_SYNC_MASK) == 8'h00 && (insel_q[3:0] == 4'h0) && !ctrl_q[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit stored");

    c_oneshot: cover property (@(posedge mclk) disable iff (!arst_n)
        st_q == DDSC_SY_ARMED ##1 nco_sync);
    c_cont: cover property (@(posedge mclk) disable iff (!arst_n)
        st_q == DDSC_SY_CONT && sync_fire);
    c_ext_fb: cover property (@(posedge mclk) disable iff (!arst_n)
        fifth_band && dec_ratio == 6'h05);
endmodule

// ===== tb/ddsc_sysref_src.sv
// System reference timing source model driving the reference pin
`timescale 1ns/1ns
module ddsc_sysref_src
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pin_en,
    input wire logic fire,
    input wire logic [7:0] period,
    output logic sysref_pin
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // ------------------------------------------------------------------
    // Edge spacing counter
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_d = 8'h00;
        if (fire)
        begin
            cnt_d = (cnt_q == period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // Fixed spacing keeps every edge a whole number of NCO periods apart
    // Pin stays low unless the testbench has enabled it
    assign sysref_pin = pin_en & fire & (cnt_q < 8'h02);
endmodule

// ===== tb/ddsc_ctrl_bench.sv
// Self-checking testbench for the downconverter sync and decimation control
`timescale 1ns/1ns
module ddsc_ctrl_bench;
    import ddsc_pkg::*;

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic pin_en = 1'b0;
    logic fire = 1'b0;
    logic [7:0] period = 8'h10;
    logic sysref_pin;
    logic [7:0] reg_rdata;
    logic nco_sync, nco_reset, gain_x2, real_out, third_band, fifth_band, cfg_valid;
    logic [1:0] if_mode;
    logic [3:0] hb_count;
    logic [5:0] dec_ratio;
    logic [7:0] rv;
    int num_errors = 0;
    int n_compared = 0;
    int n_cyc = 0;
    int n_sync = 0;
    int base;
    int hb_t[7] = '{2, 3, 4, 1, 1, 2, 3};
    int tb_t[7] = '{0, 0, 0, 0, 1, 1, 1};
    int rc_t[7] = '{4, 8, 16, 2, 6, 12, 24};
    int ex_t[3] = '{0, 2, 3};
    int eh_t[3] = '{4, 1, 2};
    int er_t[3] = '{48, 10, 20};

    always #5 mclk = ~mclk;

    ddsc_sysref_src u_src (.mclk(mclk), .arst_n(arst_n), .pin_en(pin_en), .fire(fire),
        .period(period), .sysref_pin(sysref_pin));

    ddsc_ctrl u_dut (.mclk(mclk), .arst_n(arst_n), .sysref_pin(sysref_pin),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nco_sync(nco_sync), .nco_reset(nco_reset), .gain_x2(gain_x2), .if_mode(if_mode),
        .real_out(real_out), .hb_count(hb_count), .third_band(third_band),
        .fifth_band(fifth_band), .dec_ratio(dec_ratio), .cfg_valid(cfg_valid));

    // ------------------------------------------------------------------
    // Monitors and helpers
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        n_cyc <= n_cyc + 1;
        if (nco_sync === 1'b1)
            n_sync <= n_sync + 1;
        if (n_cyc == 3000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask

    task automatic chk_cfg(input int hb, input int tb, input int fb, input int r, input int v);
        check({4'h0, hb_count}, 8'(hb), "half band count");
        check({7'h0, third_band}, 8'(tb), "third band");
        check({7'h0, fifth_band}, 8'(fb), "fifth band");
        check({2'h0, dec_ratio}, 8'(r), "decimation ratio");
        check({7'h0, cfg_valid}, 8'(v), "config valid");
    endtask

    task automatic pulses(input int n);
        base = n_sync;
        fire <= 1'b1;
        repeat (n * 16) @(posedge mclk);
        fire <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        pin_en <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk_cfg(2, 0, 0, 4, 1);
        rd(DDSC_ADDR_SYNC, rv);
        check(rv, DDSC_SYNC_RST, "sync reset value");
        rd(DDSC_ADDR_CTRL, rv);
        check(rv, DDSC_CTRL_RST, "control reset value");
        rd(DDSC_ADDR_INSEL, rv);
        check(rv, DDSC_INSEL_RST, "input select reset value");
        wr(DDSC_ADDR_CTRL, 8'hff);
        wr(DDSC_ADDR_INSEL, 8'hff);
        wr(12'h312, 8'hff);
        rd(DDSC_ADDR_CTRL, rv);
        check(rv, 8'h7f, "control reserved bit");
        rd(DDSC_ADDR_INSEL, rv);
        check(rv, 8'hf0, "input select reserved bits");
        rd(12'h312, rv);
        check(rv, 8'h00, "unmapped read");
        wr(DDSC_ADDR_SYNC, 8'hec);
        rd(DDSC_ADDR_SYNC, rv);
        check(rv, 8'h80, "sync reserved bits");
        check({7'h0, nco_reset}, 8'h00, "soft reset clear");
        wr(DDSC_ADDR_SYNC, 8'h10);
        check({7'h0, nco_reset}, 8'h01, "soft reset held");
        wr(DDSC_ADDR_SYNC, 8'h00);
        check({7'h0, nco_reset}, 8'h00, "soft reset released");
        for (int m = 0; m < 8; m++)
        begin
            wr(DDSC_ADDR_CTRL, {1'b0, m[2], m[1:0], 4'h0});
            check({7'h0, gain_x2}, {7'h0, m[2]}, "gain select");
            check({6'h0, if_mode}, {6'h0, m[1:0]}, "mixing mode");
        end
        // Extended field set to a listed code must not matter below
        wr(DDSC_ADDR_INSEL, 8'h30);
        for (int c = 0; c < 7; c++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                wr(DDSC_ADDR_CTRL, {4'h0, r[0], c[2:0]});
                check({7'h0, real_out}, {7'h0, r[0]}, "real output");
                chk_cfg(hb_t[c], tb_t[c], 0, rc_t[c] >> r, 1);
            end
        end
        for (int e = 0; e < 3; e++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                wr(DDSC_ADDR_INSEL, {4'(ex_t[e]), 4'h0});
                wr(DDSC_ADDR_CTRL, {4'h0, r[0], DDSC_DEC_EXT});
                chk_cfg(eh_t[e], e == 0, e != 0, er_t[e] >> r, 1);
            end
        end
        wr(DDSC_ADDR_INSEL, 8'h10);
        check({7'h0, cfg_valid}, 8'h00, "unlisted extended code");
        pulses(2);
        check(8'(n_sync - base), 8'h00, "sync while disabled");
        wr(DDSC_ADDR_SYNC, 8'h03);
        repeat (3) @(posedge mclk);
        pulses(3);
        check(8'(n_sync - base), 8'h01, "one-shot sync count");
        rd(DDSC_ADDR_SYNC, rv);
        check(rv, 8'h02, "one-shot enable cleared");
        pulses(2);
        check(8'(n_sync - base), 8'h00, "sync after one-shot");
        wr(DDSC_ADDR_SYNC, 8'h01);
        repeat (3) @(posedge mclk);
        pulses(3);
        check(8'(n_sync - base), 8'h03, "continuous sync count");
        rd(DDSC_ADDR_SYNC, rv);
        check(rv, 8'h01, "continuous enable kept");
        // Switching continuous to one-shot must pass through idle and re-arm
        wr(DDSC_ADDR_SYNC, 8'h03);
        pulses(2);
        check(8'(n_sync - base), 8'h01, "continuous to one-shot count");
        // Arming then clearing enable must leave no sync behind
        wr(DDSC_ADDR_SYNC, 8'h03);
        wr(DDSC_ADDR_SYNC, 8'h02);
        pulses(2);
        check(8'(n_sync - base), 8'h00, "disarmed one-shot");
        wr(DDSC_ADDR_SYNC, 8'h00);
        complete_run();
    end
endmodule
